/* rtl/frp_pkg.sv */
// Purpose: shared constants of the flash reset and protection host controller
// Assumes: 100 MHz core clock
// Notes: device lock register layout and host register map
package frp_pkg;
	localparam int CLK_MHZ = 100;
	// apb register map of the controller
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_LOCK = 8'h14;
	// control register fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_HWRST = 2;
	localparam int CTRL_SWRST = 3;
	localparam int CTRL_ABORTRST = 4;
	// status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_LOCKVALID = 2;
	localparam int ST_METHOD_ERR = 3;
	// device lock register field positions
	localparam int LR_FACTORY_OTP = 0;
	localparam int LR_PERSIST = 1;
	localparam int LR_PASSWORD = 2;
	localparam int LR_ERASE_ALL_EN = 3;
	localparam int LR_VOL_BOOT = 4;
	localparam int LR_CUST_OTP = 6;
	localparam logic [15:0] LR_RESET = 16'hFFFE;
	localparam logic [15:0] LR_RSVD_MASK = 16'hFFA0;
	// flash commands
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [23:0] ADDR_UNLOCK1 = 24'h000555;
	localparam logic [23:0] ADDR_UNLOCK2 = 24'h0002AA;
	// timing
	localparam int T_RESET_PULSE_NS = 500;
	localparam int T_RESET_PULSE_CYC = (T_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_STROBE_NS = 50;
	localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RECOVER_NS = 50;
	localparam int T_RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8;
endpackage

/* rtl/frp_timer.sv */
// Purpose: down counter used for strobe and reset pulse widths
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/100ps
module frp_timer
	import frp_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	assign done = (cnt_q == '0);
endmodule

/* rtl/frp_host.sv */
// Purpose: host controller driving a parallel nor flash for reset, command and lock register access
// Assumes: flash pins synchronous to CORE_CLK; ready_busy pulled up outside
// Notes: software builds command sequences one cycle at a time through the apb registers, except the abort recovery, which steps itself
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module frp_host
	import frp_pkg::*;
#(
	parameter int AW = 24,
	parameter int DW = 16
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [AW-1:0] FL_ADDR,
	input wire logic [DW-1:0] FL_DQ_IN,
	output logic [DW-1:0] FL_DQ_OUT,
	output logic FL_DQ_OE_N,
	output logic FL_CE_N,
	output logic FL_WE_N,
	output logic FL_OE_N,
	output logic FL_RESET_N,
	input wire logic FL_READY_BUSY_N
);
	initial begin
		// unlock addresses are 24-bit constants, so a wider bus would slice past their top bit
		if (AW < 10 || AW > 24 || DW != 16) begin
			$error("frp_host: unsupported widths");
		end
		if (T_RESET_PULSE_CYC >= (1 << CNT_W) || T_STROBE_CYC >= (1 << CNT_W) || T_RECOVER_CYC >= (1 << CNT_W)) begin
			$error("frp_host: timing count exceeds counter width");
		end
	end

	typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RDSTROBE, S_RST, S_RECOVER} frp_state_e;
	frp_state_e state_q;

	logic [AW-1:0] addr_q;
	logic [DW-1:0] wdata_q;
	logic [DW-1:0] rdata_q;
	logic [15:0] lock_q;
	logic lock_valid_q;
	logic method_err_q;
	logic is_read_q;
	logic [1:0] seq_q;
	logic abort_seq_q;
	logic tm_load;
	logic [CNT_W-1:0] tm_value;
	logic tm_done;

	logic wr_en;
	logic rd_en;
	assign wr_en = PSEL && PENABLE && PWRITE;
	// read data registered in the setup cycle so it already stands at the access edge
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

	logic busy;
	assign busy = (state_q != S_IDLE) || seq_q != 2'd0;

	// the ready pin means nothing until the final write strobe has risen, so its last trusted value is kept
	logic pin_ready_q;
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pin_ready_q <= 1'b1;
		end else if (!(state_q == S_SETUP || state_q == S_STROBE || state_q == S_HOLD)) begin
			pin_ready_q <= FL_READY_BUSY_N;
		end
	end

	logic seq_step;
	assign seq_step = state_q == S_RECOVER && tm_done && abort_seq_q;

	// launches other than the hard reset are dropped while a cycle runs; software polls busy first
	logic go_wr;
	logic go_rd;
	logic go_hwrst;
	logic go_sw;
	logic go_abort;
	always_comb begin
		go_wr = 1'b0;
		go_rd = 1'b0;
		go_hwrst = 1'b0;
		go_sw = 1'b0;
		go_abort = 1'b0;
		if (wr_en && PADDR == REG_CTRL) begin
			go_hwrst = PWDATA[CTRL_HWRST];
			if (!busy && !PWDATA[CTRL_HWRST]) begin
				go_wr = PWDATA[CTRL_GO] && !PWDATA[CTRL_RD];
				go_rd = PWDATA[CTRL_GO] && PWDATA[CTRL_RD];
				// reset only once the device reports ready
				go_sw = PWDATA[CTRL_SWRST] && pin_ready_q;
				go_abort = PWDATA[CTRL_ABORTRST];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			PRDATA <= 32'h00000000;
		end else if (rd_en) begin
			case (PADDR)
				REG_ADDR: PRDATA <= 32'(addr_q);
				REG_WDATA: PRDATA <= 32'(wdata_q);
				REG_STATUS: PRDATA <= {28'h0000000, method_err_q, lock_valid_q, pin_ready_q, busy};
				REG_RDATA: PRDATA <= 32'(rdata_q);
				REG_LOCK: PRDATA <= {16'h0000, lock_q};
				default: PRDATA <= 32'h00000000;
			endcase
		end
	end

	// sequence stepping: three cycles for the abort recovery (unlock, unlock, reset)
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			addr_q <= '0;
			wdata_q <= '0;
			is_read_q <= 1'b0;
			seq_q <= 2'd0;
			abort_seq_q <= 1'b0;
		end else if (go_hwrst) begin
			seq_q <= 2'd0;
			abort_seq_q <= 1'b0;
		end else if (go_abort) begin
			addr_q <= ADDR_UNLOCK1[AW-1:0];
			wdata_q <= CMD_UNLOCK1;
			is_read_q <= 1'b0;
			seq_q <= 2'd2;
			abort_seq_q <= 1'b1;
		end else if (go_sw) begin
			// address bits are don't care for reset
			addr_q <= '0;
			wdata_q <= CMD_RESET;
			is_read_q <= 1'b0;
		end else if (seq_step) begin
			seq_q <= seq_q - 2'd1;
			addr_q <= (seq_q == 2'd2) ? ADDR_UNLOCK2[AW-1:0] : ADDR_UNLOCK1[AW-1:0];
			wdata_q <= (seq_q == 2'd2) ? CMD_UNLOCK2 : CMD_RESET;
			if (seq_q == 2'd1) begin
				abort_seq_q <= 1'b0;
			end
		end else if (wr_en && !busy) begin
			if (PADDR == REG_ADDR) begin
				addr_q <= PWDATA[AW-1:0];
			end
			if (PADDR == REG_WDATA) begin
				wdata_q <= PWDATA[DW-1:0];
			end
			if (go_rd || go_wr) begin
				is_read_q <= go_rd;
			end
		end
	end

	logic start;
	assign start = go_wr || go_rd || go_sw || go_abort || seq_step;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_q <= S_IDLE;
		end else if (go_hwrst) begin
			state_q <= S_RST;
		end else begin
			case (state_q)
				S_IDLE: if (start) begin
					state_q <= S_SETUP;
				end
				S_RECOVER: if (tm_done) begin
					state_q <= start ? S_SETUP : S_IDLE;
				end
				S_SETUP: state_q <= is_read_q ? S_RDSTROBE : S_STROBE;
				S_STROBE: if (tm_done) begin
					state_q <= S_HOLD;
				end
				S_RDSTROBE: if (tm_done) begin
					state_q <= S_HOLD;
				end
				S_HOLD: state_q <= S_RECOVER;
				S_RST: if (tm_done) begin
					state_q <= S_RECOVER;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always_comb begin
		tm_load = 1'b0;
		tm_value = '0;
		if (go_hwrst) begin
			tm_load = 1'b1;
			tm_value = CNT_W'(T_RESET_PULSE_CYC);
		end else if (state_q == S_SETUP) begin
			tm_load = 1'b1;
			tm_value = CNT_W'(T_STROBE_CYC);
		// the device also gets a quiet gap after the reset pulse before the next command
		end else if (state_q == S_HOLD || (state_q == S_RST && tm_done)) begin
			tm_load = 1'b1;
			tm_value = CNT_W'(T_RECOVER_CYC);
		end
	end

	frp_timer #(.W(CNT_W)) u_timer (
		.clk(CORE_CLK),
		.rst(RESET),
		.load(tm_load),
		.value(tm_value),
		.done(tm_done)
	);

	// address set during setup, strobes fall after; data kept through hold
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			FL_CE_N <= 1'b1;
			FL_WE_N <= 1'b1;
			FL_OE_N <= 1'b1;
			FL_DQ_OE_N <= 1'b1;
			FL_ADDR <= '0;
			FL_DQ_OUT <= '0;
			FL_RESET_N <= 1'b0;
		end else begin
			FL_RESET_N <= !(go_hwrst || (state_q == S_RST && !tm_done));
			FL_ADDR <= addr_q;
			FL_DQ_OUT <= wdata_q;
			// a reset order cuts a running strobe at once so no access overlaps the reset pulse
			FL_DQ_OE_N <= go_hwrst || !((state_q == S_SETUP || state_q == S_STROBE || state_q == S_HOLD) && !is_read_q);
			FL_CE_N <= go_hwrst || !(state_q == S_STROBE || state_q == S_RDSTROBE);
			FL_WE_N <= go_hwrst || !(state_q == S_STROBE);
			FL_OE_N <= go_hwrst || !(state_q == S_RDSTROBE);
		end
	end

	// lock register read: decode kept for software and method sanity
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rdata_q <= '0;
			lock_q <= LR_RESET;
			lock_valid_q <= 1'b0;
			method_err_q <= 1'b0;
		end else if (state_q == S_RDSTROBE && tm_done) begin
			rdata_q <= FL_DQ_IN;
			if (addr_q == '0) begin
				// reserved bits forced high so a stray bus value cannot look like a method choice
				lock_q <= FL_DQ_IN | LR_RSVD_MASK;
				lock_valid_q <= 1'b1;
				method_err_q <= !FL_DQ_IN[LR_PERSIST] && !FL_DQ_IN[LR_PASSWORD];
			end
		end
	end
endmodule

/* sim/frp_host_monitor.sv */
// Purpose: pin and apb checks beside the flash host controller
// Assumes: bound to frp_host, one clock domain
// Notes: strobe widths follow the hand-over walk
`timescale 1ns/100ps
module frp_host_monitor
	import frp_pkg::*;
#(
	parameter int AW = 24,
	parameter int DW = 16
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [AW-1:0] FL_ADDR,
	input wire logic [DW-1:0] FL_DQ_IN,
	input wire logic [DW-1:0] FL_DQ_OUT,
	input wire logic FL_DQ_OE_N,
	input wire logic FL_CE_N,
	input wire logic FL_WE_N,
	input wire logic FL_OE_N,
	input wire logic FL_RESET_N,
	input wire logic FL_READY_BUSY_N
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	property p_wr_levels; !FL_WE_N |-> !FL_CE_N && FL_OE_N && !FL_DQ_OE_N; endproperty
	a_wr_levels: assert property (p_wr_levels) else $error("bad write strobe levels");
	property p_rd_levels; !FL_OE_N |-> !FL_CE_N && FL_WE_N && FL_DQ_OE_N; endproperty
	a_rd_levels: assert property (p_rd_levels) else $error("bus fight on read");
	property p_wr_hold; !FL_WE_N && $past(!FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("address or data moved in write");
	property p_wr_width; $fell(FL_WE_N) |-> !FL_WE_N [*6] ##1 FL_WE_N; endproperty
	a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
	property p_wr_gap; $rose(FL_WE_N) |-> FL_WE_N [*2]; endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("write strobes too close");
	property p_rst_quiet; !FL_RESET_N |-> FL_CE_N && FL_WE_N && FL_OE_N; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("access during reset pulse");
	property p_rst_width; $fell(FL_RESET_N) |-> ##49 !FL_RESET_N; endproperty
	a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
	property p_apb_ok; PSEL && PENABLE |-> PREADY && !PSLVERR; endproperty
	a_apb_ok: assert property (p_apb_ok) else $error("apb answer wrong");
endmodule
bind frp_host frp_host_monitor #(.AW(AW), .DW(DW)) frp_host_monitor_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR), .FL_DQ_IN(FL_DQ_IN), .FL_DQ_OUT(FL_DQ_OUT),
	.FL_DQ_OE_N(FL_DQ_OE_N), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N),
	.FL_RESET_N(FL_RESET_N), .FL_READY_BUSY_N(FL_READY_BUSY_N));

/* sim/frp_flash_model.sv */
// Purpose: behavioural flash device facing the host controller
// Assumes: pins sampled on the core clock
// Notes: reset, busy, lock register reads and sector guards are modelled; 0040 enters lock read,
// 0060 protects a sector, 0061 sets its persistent guard, 0050 clears the guard lock
`timescale 1ns/100ps
module frp_flash_model #(
	parameter logic [15:0] LOCK_VAL = 16'h0036,
	parameter int BUSY_CYC = 60
) (
	input wire logic clk,
	input wire logic [23:0] addr,
	input wire logic [15:0] din,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic rst_n,
	output logic [15:0] dout,
	output logic ready_busy_n
);
	logic act_q = 1'b0;
	logic lock_q = 1'b0;
	logic [15:0] dout_q = 16'h1234;
	int busy_q = 0;
	// one guard pair per 64K-word sector, indexed by the top address byte
	logic [255:0] pers_guard_q = '1;
	logic [255:0] vol_guard_q = '1;
	logic guard_lock_q = 1'b1;
	logic [7:0] sect;
	assign sect = addr[23:16];
	always @(posedge clk) begin
		act_q <= !ce_n && !we_n;
		if (!rst_n) begin
			lock_q <= 1'b0;
			busy_q <= 0;
			guard_lock_q <= LOCK_VAL[2];
			vol_guard_q <= {256{LOCK_VAL[4]}};
		end else if (act_q && (ce_n || we_n)) begin
			if (din == 16'h00F0 && busy_q == 0) lock_q <= 1'b0;
			else if (din == 16'h00A0 && pers_guard_q[sect] && vol_guard_q[sect]) busy_q <= BUSY_CYC;
			else if (din == 16'h0040) lock_q <= 1'b1;
			else if (din == 16'h0060) vol_guard_q[sect] <= 1'b0;
			else if (din == 16'h0061 && guard_lock_q) pers_guard_q[sect] <= 1'b0;
			else if (din == 16'h0050) guard_lock_q <= 1'b0;
		end else if (busy_q != 0) busy_q <= busy_q - 1;
		if (!ce_n && !oe_n && rst_n) dout_q <= lock_q ? ((LOCK_VAL | 16'hFFA0) & 16'hFFFE) : (addr[15:0] ^ 16'h5A5A);
		else dout_q <= ~dout_q; // released bus inverts its last value every cycle instead of holding it
	end
	assign dout = dout_q;
	assign ready_busy_n = (busy_q == 0) ? 1'b1 : 1'b0;
endmodule

/* sim/flash_reset_and_sector_protection_test.sv */
// Purpose: self-checking bench of the flash host controller
// Assumes: zero wait apb slave, flash model on the pins
// Notes: device busy kept short by the model parameter
`timescale 1ns/100ps
module flash_reset_and_sector_protection_test;
	import frp_pkg::*;
	localparam logic [15:0] LOCK_VAL = 16'h0036;
	logic CORE_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, r;
	logic PREADY, PSLVERR, FL_DQ_OE_N, FL_CE_N, FL_WE_N, FL_OE_N, FL_RESET_N, FL_READY_BUSY_N;
	logic [23:0] FL_ADDR, a;
	logic [15:0] FL_DQ_IN, FL_DQ_OUT;
	int fail_count = 0;
	int tests_run = 0;
	initial forever #5 CORE_CLK = ~CORE_CLK;
	frp_host frp_host_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR),
		.FL_DQ_IN(FL_DQ_IN), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE_N(FL_DQ_OE_N), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
		.FL_OE_N(FL_OE_N), .FL_RESET_N(FL_RESET_N), .FL_READY_BUSY_N(FL_READY_BUSY_N));
	frp_flash_model #(.LOCK_VAL(LOCK_VAL), .BUSY_CYC(60)) frp_flash_model_i (.clk(CORE_CLK), .addr(FL_ADDR),
		.din(FL_DQ_OUT), .ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N), .rst_n(FL_RESET_N), .dout(FL_DQ_IN),
		.ready_busy_n(FL_READY_BUSY_N));
	function automatic logic [31:0] arr(input logic [23:0] x);
		return {16'h0, x[15:0] ^ 16'h5A5A};
	endfunction
	function automatic logic [31:0] lockv();
		return {16'h0, 9'h1FF, LOCK_VAL[6], 1'b1, LOCK_VAL[4:1], 1'b0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int n = 0;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= ad;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		@(posedge CORE_CLK);
		while (PREADY !== 1'b1 && n < 50) begin
			@(posedge CORE_CLK);
			n++;
		end
		if (n >= 50) fail_count++;
		r = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wait_st(input int b, input logic v);
		int n = 0;
		apb(1'b0, REG_STATUS, 32'h0);
		while (r[b] !== v && n < 300) begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		chk({31'h0, r[b]}, {31'h0, v});
	endtask
	task automatic fop(input logic [23:0] ad, input logic [15:0] d, input logic [31:0] c);
		apb(1'b1, REG_ADDR, {8'h0, ad});
		apb(1'b1, REG_WDATA, {16'h0, d});
		apb(1'b1, REG_CTRL, c);
		wait_st(ST_BUSY, 1'b0);
		apb(1'b0, REG_RDATA, 32'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end
	initial begin
		void'($urandom(18139));
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		apb(1'b0, 8'h1C, 32'h0);
		chk(r, 32'h0);
		$display("test reset_state done");
		for (int i = 0; i < 5; i++) begin
			a = (i == 0) ? 24'hFFFFFF : 24'($urandom);
			fop(a, 16'h0, 32'h3);
			chk(r, arr(a));
		end
		$display("test array_read done");
		fop(24'h0, 16'h0040, 32'h1);
		fop(24'h0, 16'h0, 32'h3);
		chk(r, lockv());
		apb(1'b0, REG_LOCK, 32'h0);
		chk(r, lockv());
		apb(1'b0, REG_STATUS, 32'h0);
		chk({30'h0, r[ST_METHOD_ERR], r[ST_LOCKVALID]}, 32'h1);
		$display("test lock_read done");
		fop(24'h0, 16'h00A0, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[ST_READY]}, 32'h0);
		apb(1'b1, REG_CTRL, 32'h1 << CTRL_SWRST);
		wait_st(ST_READY, 1'b1);
		fop(24'h0, 16'h0, 32'h3);
		chk(r, lockv());
		$display("test busy_refuse done");
		apb(1'b1, REG_CTRL, 32'h1 << CTRL_SWRST);
		wait_st(ST_BUSY, 1'b0);
		fop(24'h0, 16'h0, 32'h3);
		chk(r, arr(24'h0));
		$display("test soft_reset done");
		for (int i = 0; i < 2; i++) begin
			fop(24'h0, 16'h0040, 32'h1);
			apb(1'b1, REG_CTRL, 32'h1 << ((i == 0) ? CTRL_HWRST : CTRL_ABORTRST));
			wait_st(ST_BUSY, 1'b0);
			fop(24'h0, 16'h0, 32'h3);
			chk(r, arr(24'h0));
		end
		$display("test hard_and_abort_reset done");
		fop(24'h050000, 16'h0060, 32'h1);
		fop(24'h050000, 16'h00A0, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[ST_READY]}, 32'h1);
		fop(24'h060000, 16'h0061, 32'h1);
		fop(24'h060000, 16'h00A0, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[ST_READY]}, 32'h1);
		fop(24'h0, 16'h0050, 32'h1);
		fop(24'h070000, 16'h0061, 32'h1);
		fop(24'h070000, 16'h00A0, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[ST_READY]}, 32'h0);
		wait_st(ST_READY, 1'b1);
		apb(1'b1, REG_CTRL, 32'h1 << CTRL_HWRST);
		wait_st(ST_BUSY, 1'b0);
		fop(24'h050000, 16'h00A0, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[ST_READY]}, 32'h0);
		wait_st(ST_READY, 1'b1);
		$display("test sector_guard done");
		end_sim();
	end
endmodule
